// file: hw/ute_regs.sv
// task triggers, event flags and receive-to-memory path of a serial port
// assumes a plain register port (read data one cycle after the read strobe)
// and a byte-capture front end delivering rx_byte_valid_i pulses
//
// The strobed register port was decided locally.
`timescale 1ns/100ps
`include "ute_cfg.svh"

// Overview of operation
// - drain trigger moves remaining receive FIFO bytes into the memory buffer
// - send-permit line going low sets the send-permitted event flag
// - send-permit line going high sets the send-forbidden event flag
// - captured character sets byte-received flag, possibly before memory write
// - memory buffer filled with the maximum byte count sets buffer-full flag
module ute_regs
  import ute_pkg::*;
#(
  parameter int FIFO_DEPTH = 4,
  parameter int CNT_W = 8
) (
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_i,
  // register port
  input wire logic [11:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [31:0] rdata_o,
  // serial side
  input wire logic cts_n_i,
  input wire logic rx_byte_valid_i,
  input wire logic [7:0] rx_byte_i,
  output logic rx_byte_ready_o,
  // receive memory write port
  output logic mem_we_o,
  output logic [CNT_W-1:0] mem_addr_o,
  output logic [7:0] mem_wdata_o,
  // task pulses toward the transmitter/receiver, and the receiver running level
  output logic rx_stop_o,
  output logic tx_start_o,
  output logic tx_stop_o,
  output logic rx_running_o,
  // interrupt
  output logic irq_o
);
  typedef struct packed {
    ute_rx_state_t rx_state;
    logic cts_prev;
    ute_events_t ev;
    ute_events_t irq_stat;
    ute_events_t irq_en;
    logic [CNT_W-1:0] maxcnt;
    logic [CNT_W-1:0] amount;
    logic [31:0] rdata;
    logic rx_stop;
    logic tx_start;
    logic tx_stop;
    logic mem_we;
    logic [CNT_W-1:0] mem_addr;
    logic [7:0] mem_wdata;
  } ute_state_t;

  ute_state_t st_ff;
  ute_state_t nxt_st;
  logic cts_sync;
  logic fifo_out_valid;
  logic [7:0] fifo_out_data;
  logic fifo_pop;
  logic buf_room;
  ute_events_t ev_set;
  ute_events_t ev_wclr;

  ute_sync u_cts_sync (
    .ref_clk_i(ref_clk_i),
    .rst_i(rst_i),
    .async_i(cts_n_i),
    .sync_o(cts_sync)
  );

  // stalls the byte-capture front end when full
  ute_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_rx_fifo (
    .ref_clk_i(ref_clk_i),
    .rst_i(rst_i),
    .in_valid_i(rx_byte_valid_i),
    .in_data_i(rx_byte_i),
    .in_ready_o(rx_byte_ready_o),
    .out_valid_o(fifo_out_valid),
    .out_data_o(fifo_out_data),
    .out_ready_i(fifo_pop)
  );

  function automatic logic wr_hit(input logic [11:0] ofs);
    wr_hit = wr_i && (addr_i == ofs);
  endfunction

  function automatic logic fire(input logic [11:0] ofs);
    fire = wr_hit(ofs) && wdata_i[`UTE_BIT_TRIG];
  endfunction

  // bytes reach memory only while the receiver runs or drains, and room remains
  assign buf_room = (st_ff.amount != st_ff.maxcnt);
  assign fifo_pop = fifo_out_valid && buf_room &&
                    (st_ff.rx_state != UTE_RX_IDLE);

  always_comb begin
    ev_set = '0;
    ev_set[`UTE_EV_PERMIT] = st_ff.cts_prev && !cts_sync;
    ev_set[`UTE_EV_FORBID] = !st_ff.cts_prev && cts_sync;
    ev_set[`UTE_EV_BYTE] = rx_byte_valid_i && rx_byte_ready_o;
    ev_set[`UTE_EV_FULL] = fifo_pop &&
      (st_ff.amount == CNT_W'(st_ff.maxcnt - 1'b1));
    ev_wclr = '0;
    ev_wclr[`UTE_EV_PERMIT] = wr_hit(`UTE_OFS_EV_PERMIT) && !wdata_i[`UTE_BIT_TRIG];
    ev_wclr[`UTE_EV_FORBID] = wr_hit(`UTE_OFS_EV_FORBID) && !wdata_i[`UTE_BIT_TRIG];
    ev_wclr[`UTE_EV_BYTE] = wr_hit(`UTE_OFS_EV_BYTE) && !wdata_i[`UTE_BIT_TRIG];
    ev_wclr[`UTE_EV_FULL] = wr_hit(`UTE_OFS_EV_FULL) && !wdata_i[`UTE_BIT_TRIG];
  end

  always_comb begin
    nxt_st = st_ff;
    nxt_st.cts_prev = cts_sync;
    // trigger pulses last one cycle; a zero write leaves them low
    nxt_st.rx_stop = fire(`UTE_OFS_RX_STOP);
    nxt_st.tx_start = fire(`UTE_OFS_TX_START);
    nxt_st.tx_stop = fire(`UTE_OFS_TX_STOP);
    nxt_st.mem_we = fifo_pop;
    if (fifo_pop) begin
      nxt_st.mem_addr = st_ff.amount;
      nxt_st.mem_wdata = fifo_out_data;
      nxt_st.amount = CNT_W'(st_ff.amount + 1'b1);
    end
    // set wins over clear, both for event registers and interrupt status
    nxt_st.ev = (st_ff.ev & ~ev_wclr) | ev_set;
    if (wr_hit(`UTE_OFS_EV_PERMIT) && wdata_i[`UTE_BIT_TRIG]) begin
      nxt_st.ev[`UTE_EV_PERMIT] = 1'b1;
    end
    if (wr_hit(`UTE_OFS_IRQ_CLR)) begin
      nxt_st.irq_stat = (st_ff.irq_stat & ~wdata_i[3:0]) | ev_set;
    end else begin
      nxt_st.irq_stat = st_ff.irq_stat | ev_set;
    end
    if (wr_hit(`UTE_OFS_IRQ_EN)) begin
      nxt_st.irq_en = wdata_i[3:0];
    end
    if (wr_hit(`UTE_OFS_MAXCNT)) begin
      nxt_st.maxcnt = wdata_i[CNT_W-1:0];
    end
    case (st_ff.rx_state)
      UTE_RX_IDLE: begin
        // new buffer: reception restarts from the first byte
        if (wr_hit(`UTE_OFS_AMOUNT)) begin
          nxt_st.amount = '0;
          nxt_st.rx_state = UTE_RX_RUN;
        end else if (fire(`UTE_OFS_RX_DRAIN)) begin
          nxt_st.rx_state = UTE_RX_DRAIN;
        end
      end
      UTE_RX_RUN: begin
        if (fire(`UTE_OFS_RX_STOP) || ev_set[`UTE_EV_FULL]) begin
          nxt_st.rx_state = UTE_RX_IDLE;
        end else if (fire(`UTE_OFS_RX_DRAIN)) begin
          nxt_st.rx_state = UTE_RX_DRAIN;
        end
      end
      UTE_RX_DRAIN: begin
        // drain ends when FIFO empties or the buffer fills
        if (!fifo_out_valid || (fifo_pop && !fifo_out_valid) || ev_set[`UTE_EV_FULL] ||
            !buf_room) begin
          nxt_st.rx_state = UTE_RX_IDLE;
        end
      end
      default: nxt_st.rx_state = UTE_RX_IDLE;
    endcase
    nxt_st.rdata = '0;
    if (rd_i) begin
      case (addr_i)
        `UTE_OFS_EV_PERMIT: nxt_st.rdata = {31'h0, st_ff.ev[`UTE_EV_PERMIT]};
        `UTE_OFS_EV_FORBID: nxt_st.rdata = {31'h0, st_ff.ev[`UTE_EV_FORBID]};
        `UTE_OFS_EV_BYTE: nxt_st.rdata = {31'h0, st_ff.ev[`UTE_EV_BYTE]};
        `UTE_OFS_EV_FULL: nxt_st.rdata = {31'h0, st_ff.ev[`UTE_EV_FULL]};
        `UTE_OFS_IRQ_STAT: nxt_st.rdata = {28'h0, st_ff.irq_stat};
        `UTE_OFS_IRQ_EN: nxt_st.rdata = {28'h0, st_ff.irq_en};
        `UTE_OFS_MAXCNT: nxt_st.rdata = 32'(st_ff.maxcnt);
        `UTE_OFS_AMOUNT: nxt_st.rdata = 32'(st_ff.amount);
        `UTE_OFS_STATE: nxt_st.rdata = {29'h0, st_ff.rx_state};
        default: nxt_st.rdata = `UTE_RST_ZERO;
      endcase
    end
  end

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      st_ff <= '0;
      st_ff.rx_state <= UTE_RX_IDLE;
      st_ff.cts_prev <= 1'b1;
      st_ff.maxcnt <= `UTE_RST_MAXCNT;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign rdata_o = st_ff.rdata;
  assign mem_we_o = st_ff.mem_we;
  assign mem_addr_o = st_ff.mem_addr;
  assign mem_wdata_o = st_ff.mem_wdata;
  assign rx_stop_o = st_ff.rx_stop;
  assign tx_start_o = st_ff.tx_start;
  assign tx_stop_o = st_ff.tx_stop;
  assign rx_running_o = (st_ff.rx_state == UTE_RX_RUN);
  assign irq_o = |(st_ff.irq_stat & st_ff.irq_en);

  // a zero write to a trigger must not pulse
  a_trig_zero_quiet: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (wr_i && addr_i == `UTE_OFS_TX_START && !wdata_i[0]) |=> !tx_start_o)
    else $error("start pulse after zero write");

  // back-to-back trigger writes legally stretch the pulse
  a_trig_one_fires: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (wr_i && addr_i == `UTE_OFS_TX_STOP && wdata_i[0]) |=> tx_stop_o ##1
    (!tx_stop_o || $past(wr_i && addr_i == `UTE_OFS_TX_STOP && wdata_i[0])))
    else $error("stop pulse not exactly one cycle");

  a_start_fires: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (wr_i && addr_i == `UTE_OFS_TX_START && wdata_i[0]) |=> tx_start_o)
    else $error("start pulse missing");

  a_rx_stop_zero: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (wr_i && addr_i == `UTE_OFS_RX_STOP && !wdata_i[0]) |=> !rx_stop_o)
    else $error("receiver stop pulse after zero write");

  a_stop_ends_run: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (rx_running_o && wr_i && addr_i == `UTE_OFS_RX_STOP && wdata_i[0]) |=> !rx_running_o)
    else $error("receiver still running after stop");

  sequence s_drain_req;
    st_ff.rx_state == UTE_RX_IDLE && wr_i && addr_i == `UTE_OFS_RX_DRAIN && wdata_i[0];
  endsequence
  sequence s_drain_active;
    st_ff.rx_state == UTE_RX_DRAIN;
  endsequence
  a_drain_starts: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    s_drain_req |=> s_drain_active)
    else $error("drain trigger ignored");

  a_drain_writes: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (s_drain_active and fifo_out_valid and buf_room) |=> mem_we_o)
    else $error("drain did not write memory");

  a_permit_event: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    $fell(cts_sync) |=> st_ff.ev[`UTE_EV_PERMIT] && st_ff.irq_stat[`UTE_EV_PERMIT])
    else $error("permit flag not set");

  a_forbid_event: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    $rose(cts_sync) |=> st_ff.ev[`UTE_EV_FORBID] && st_ff.irq_stat[`UTE_EV_FORBID])
    else $error("forbid flag not set");

  a_byte_event: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (rx_byte_valid_i && rx_byte_ready_o) |=> st_ff.ev[`UTE_EV_BYTE])
    else $error("byte flag not set");

  a_full_event: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (mem_we_o && mem_addr_o == CNT_W'(st_ff.maxcnt - 1'b1)) |-> st_ff.ev[`UTE_EV_FULL])
    else $error("full flag missing at last byte");

  // a clear write racing a new byte must lose
  a_byte_set_wins: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (rx_byte_valid_i && rx_byte_ready_o && wr_i && addr_i == `UTE_OFS_EV_BYTE &&
     !wdata_i[0]) |=> st_ff.ev[`UTE_EV_BYTE])
    else $error("byte flag lost to clear");

  a_byte_status: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (rx_byte_valid_i && rx_byte_ready_o) |=> st_ff.irq_stat[`UTE_EV_BYTE])
    else $error("byte status bit not set");

  // bytes wait in the FIFO while the receiver is idle
  a_idle_no_write: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (st_ff.rx_state == UTE_RX_IDLE) |=> !mem_we_o)
    else $error("memory written while idle");

  sequence s_last_byte;
    fifo_pop && (st_ff.amount == CNT_W'(st_ff.maxcnt - 1'b1));
  endsequence
  sequence s_drain_empty;
    s_drain_active ##0 !fifo_out_valid;
  endsequence

  a_full_stops: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    s_last_byte |=> (st_ff.rx_state == UTE_RX_IDLE) && st_ff.ev[`UTE_EV_FULL])
    else $error("receiver not idle after full buffer");

  a_no_overrun: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    !buf_room |=> !mem_we_o)
    else $error("memory written past buffer end");

  a_drain_ends: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    s_drain_empty |=> st_ff.rx_state == UTE_RX_IDLE)
    else $error("drain did not end on empty FIFO");

  // consecutive memory writes walk the buffer in arrival order
  a_addr_order: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    mem_we_o |=> !mem_we_o || (mem_addr_o == CNT_W'($past(mem_addr_o) + 1'b1)))
    else $error("memory address skipped");

  a_amount_restart: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (st_ff.rx_state == UTE_RX_IDLE && wr_i && addr_i == `UTE_OFS_AMOUNT) |=>
    rx_running_o && (st_ff.amount == '0))
    else $error("new buffer did not start reception");

  // read data stands only in the cycle after a read strobe
  a_rdata_idle: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    !rd_i |=> (rdata_o == `UTE_RST_ZERO))
    else $error("read data not idle");
endmodule

// file: hw/ute_cfg.svh
// register offsets, field positions, reset values and counts of the task/event block
// assumes a 12-bit byte address on the plain register port
`ifndef UTE_CFG_SVH
`define UTE_CFG_SVH
`define UTE_OFS_RX_STOP 12'h004
`define UTE_OFS_TX_START 12'h008
`define UTE_OFS_TX_STOP 12'h00C
`define UTE_OFS_RX_DRAIN 12'h02C
`define UTE_OFS_EV_PERMIT 12'h100
`define UTE_OFS_EV_FORBID 12'h104
`define UTE_OFS_EV_BYTE 12'h108
`define UTE_OFS_EV_FULL 12'h110
`define UTE_OFS_IRQ_STAT 12'h600
`define UTE_OFS_IRQ_CLR 12'h604
`define UTE_OFS_IRQ_EN 12'h608
`define UTE_OFS_MAXCNT 12'h60C
`define UTE_OFS_AMOUNT 12'h610
`define UTE_OFS_STATE 12'h614
`define UTE_BIT_TRIG 0
`define UTE_EV_PERMIT 0
`define UTE_EV_FORBID 1
`define UTE_EV_BYTE 2
`define UTE_EV_FULL 3
`define UTE_RST_MAXCNT 8'h10
`define UTE_RST_ZERO 32'h0000_0000
`endif

// file: hw/ute_pkg.sv
// types shared by the task/event block and its helpers
package ute_pkg;
  typedef enum logic [2:0] {
    UTE_RX_IDLE = 3'b001,
    UTE_RX_RUN = 3'b010,
    UTE_RX_DRAIN = 3'b100
  } ute_rx_state_t;
  typedef logic [3:0] ute_events_t;
endpackage

// file: hw/ute_sync.sv
// two-flop synchroniser for a level from a pin
// assumes the input is asynchronous to ref_clk_i
`timescale 1ns/100ps
module ute_sync (
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_i,
  // level
  input wire logic async_i,
  output logic sync_o
);
  typedef struct packed {
    logic meta;
    logic sync;
  } ute_sync_state_t;
  ute_sync_state_t st_ff;
  ute_sync_state_t nxt_st;
  always_comb begin
    nxt_st.meta = async_i;
    nxt_st.sync = st_ff.meta;
  end
  // reset high: the send-permit line idles high (forbidden)
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      st_ff <= 2'b11;
    end else begin
      st_ff <= nxt_st;
    end
  end
  assign sync_o = st_ff.sync;
endmodule

// file: hw/ute_fifo.sv
// small receive FIFO in flip-flops, valid/ready on both sides
// assumes one clock; push and pop may coincide
`timescale 1ns/100ps
module ute_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_i,
  // fill side
  input wire logic in_valid_i,
  input wire logic [WIDTH-1:0] in_data_i,
  output logic in_ready_o,
  // drain side
  output logic out_valid_o,
  output logic [WIDTH-1:0] out_data_o,
  input wire logic out_ready_i
);
  localparam int AW = $clog2(DEPTH);
  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0] wr;
    logic [AW-1:0] rd;
    logic [AW:0] cnt;
  } ute_fifo_state_t;
  ute_fifo_state_t st_ff;
  ute_fifo_state_t nxt_st;
  logic push;
  logic pop;
  function automatic logic [AW-1:0] ute_inc(input logic [AW-1:0] p);
    ute_inc = (p == AW'(DEPTH - 1)) ? '0 : AW'(p + 1'b1);
  endfunction
  assign in_ready_o = (st_ff.cnt != (AW+1)'(DEPTH));
  assign out_valid_o = (st_ff.cnt != '0);
  assign out_data_o = st_ff.mem[st_ff.rd];
  assign push = in_valid_i && in_ready_o;
  assign pop = out_valid_o && out_ready_i;
  always_comb begin
    nxt_st = st_ff;
    if (push) begin
      nxt_st.mem[st_ff.wr] = in_data_i;
      nxt_st.wr = ute_inc(st_ff.wr);
    end
    if (pop) begin
      nxt_st.rd = ute_inc(st_ff.rd);
    end
    nxt_st.cnt = (AW+1)'(st_ff.cnt + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop});
  end
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end
endmodule

// file: testbench/ute_remote_model.sv
// remote serial party: drives the send-permit pin and captured bytes
// assumes the bench calls its tasks; shares the block's clock
`timescale 1ns/100ps
module ute_remote_model (
  // clock
  input wire logic ref_clk_i,
  // toward the block
  output logic cts_n_o,
  output logic byte_valid_o,
  output logic [7:0] byte_o,
  input wire logic byte_ready_i
);
  initial begin
    cts_n_o = 1'b1;
    byte_valid_o = 1'b0;
    byte_o = 8'h00;
  end
  task automatic set_cts_n(input logic lvl);
    @(posedge ref_clk_i);
    cts_n_o <= lvl;
  endtask
  // valid held until ready seen at an edge; idle byte shows the inverse
  task automatic send(input logic [7:0] b);
    @(posedge ref_clk_i);
    byte_valid_o <= 1'b1;
    byte_o <= b;
    @(posedge ref_clk_i);
    while (byte_ready_i !== 1'b1) @(posedge ref_clk_i);
    byte_valid_o <= 1'b0;
    byte_o <= ~b;
  endtask
endmodule

// file: testbench/ute_regs_tb.sv
// self-checking bench of the task/event block
// assumes the remote model drives the serial side; memory writes are logged
`timescale 1ns/100ps
`include "ute_cfg.svh"
module ute_regs_tb;
  import ute_pkg::*;
  logic ref_clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [11:0] addr_i = 12'h000;
  logic [31:0] wdata_i = 32'h0;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic [31:0] rdata_o;
  logic cts_n, bv, br, we, rxs, txs, txp, run, irq;
  logic [7:0] bd, ma, md;
  logic [31:0] r;
  int error_cnt = 0;
  int checks_done = 0;
  int cyc = 0;
  logic [7:0] qa[$];
  logic [7:0] qd[$];

  ute_remote_model rm (.ref_clk_i(ref_clk_i), .cts_n_o(cts_n), .byte_valid_o(bv),
    .byte_o(bd), .byte_ready_i(br));
  ute_regs dut (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .cts_n_i(cts_n), .rx_byte_valid_i(bv),
    .rx_byte_i(bd), .rx_byte_ready_o(br), .mem_we_o(we), .mem_addr_o(ma),
    .mem_wdata_o(md), .rx_stop_o(rxs), .tx_start_o(txs), .tx_stop_o(txp),
    .rx_running_o(run), .irq_o(irq));

  initial begin
    forever #25 ref_clk_i = ~ref_clk_i;
  end
  always @(posedge ref_clk_i) begin
    cyc <= cyc + 1;
    if (we === 1'b1) begin
      qa.push_back(ma);
      qd.push_back(md);
    end
    if (cyc == 20000) begin
      error_cnt++;
      give_verdict();
    end
  end

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge ref_clk_i);
    wr_i <= 1'b1;
    addr_i <= a;
    wdata_i <= d;
    @(posedge ref_clk_i);
    wr_i <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [11:0] a, output logic [31:0] d);
    @(posedge ref_clk_i);
    rd_i <= 1'b1;
    addr_i <= a;
    @(posedge ref_clk_i);
    rd_i <= 1'b0;
    #1;
    d = rdata_o;
  endtask
  function automatic logic pulse(input int i);
    return (i == 0) ? rxs : (i == 1) ? txs : txp;
  endfunction

  task automatic t_reset_values();
    rd(`UTE_OFS_EV_PERMIT, r); chk("permit rst", 32'h0, r);
    rd(`UTE_OFS_EV_FULL, r); chk("full rst", 32'h0, r);
    rd(`UTE_OFS_MAXCNT, r); chk("maxcnt rst", 32'h10, r);
    rd(12'h7FC, r); chk("unmapped", 32'h0, r);
    $display("test reset values done");
  endtask
  task automatic t_triggers();
    logic [11:0] ofs[3];
    ofs = '{`UTE_OFS_RX_STOP, `UTE_OFS_TX_START, `UTE_OFS_TX_STOP};
    for (int i = 0; i < 3; i++) begin
      wr(ofs[i], 32'h0);
      chk("trigger zero", 32'h0, {31'h0, pulse(i)});
      wr(ofs[i], 32'h1);
      chk("trigger pulse", 32'h1, {31'h0, pulse(i)});
      @(posedge ref_clk_i);
      #1;
      chk("trigger once", 32'h0, {31'h0, pulse(i)});
      rd(ofs[i], r); chk("trigger wo", 32'h0, r);
    end
    $display("test triggers done");
  endtask
  task automatic t_cts();
    wr(`UTE_OFS_IRQ_EN, 32'h1);
    rm.set_cts_n(1'b0);
    repeat (6) @(posedge ref_clk_i);
    rd(`UTE_OFS_EV_PERMIT, r); chk("permit ev", 32'h1, r);
    rd(`UTE_OFS_EV_FORBID, r); chk("forbid quiet", 32'h0, r);
    chk("irq on", 32'h1, {31'h0, irq});
    wr(`UTE_OFS_IRQ_CLR, 32'h1);
    #1;
    chk("irq off", 32'h0, {31'h0, irq});
    wr(`UTE_OFS_EV_PERMIT, 32'h0);
    rd(`UTE_OFS_EV_PERMIT, r); chk("permit clr", 32'h0, r);
    rm.set_cts_n(1'b1);
    repeat (6) @(posedge ref_clk_i);
    rd(`UTE_OFS_EV_FORBID, r); chk("forbid ev", 32'h1, r);
    rd(`UTE_OFS_IRQ_STAT, r); chk("irq stat", 32'h2, r);
    chk("irq masked", 32'h0, {31'h0, irq});
    $display("test send permit done");
  endtask
  task automatic t_receive();
    wr(`UTE_OFS_MAXCNT, 32'h2);
    wr(`UTE_OFS_AMOUNT, 32'h0);
    rm.send(8'hA5);
    rm.send(8'h3C);
    repeat (6) @(posedge ref_clk_i);
    rd(`UTE_OFS_EV_BYTE, r); chk("byte ev", 32'h1, r);
    rd(`UTE_OFS_EV_FULL, r); chk("full ev", 32'h1, r);
    rd(`UTE_OFS_AMOUNT, r); chk("amount", 32'h2, r);
    rd(`UTE_OFS_STATE, r); chk("idle", 32'h1, r);
    chk("mem count", 32'h2, qa.size());
    chk("mem a0", 32'h0, {24'h0, qa[0]});
    chk("mem d0", 32'hA5, {24'h0, qd[0]});
    chk("mem d1", 32'h3C, {24'h0, qd[1]});
    $display("test receive done");
  endtask
  task automatic t_drain();
    wr(`UTE_OFS_MAXCNT, 32'h4);
    rm.send(8'h7E);
    wr(`UTE_OFS_RX_DRAIN, 32'h0);
    repeat (4) @(posedge ref_clk_i);
    chk("held in fifo", 32'h2, qa.size());
    wr(`UTE_OFS_RX_DRAIN, 32'h1);
    repeat (6) @(posedge ref_clk_i);
    chk("drained count", 32'h3, qa.size());
    chk("drained addr", 32'h2, {24'h0, qa[2]});
    chk("drained data", 32'h7E, {24'h0, qd[2]});
    $display("test drain done");
  endtask
  task automatic t_stop();
    wr(`UTE_OFS_AMOUNT, 32'h0);
    chk("run on", 32'h1, {31'h0, run});
    // no disable ever follows a stop in this bench
    wr(`UTE_OFS_RX_STOP, 32'h1);
    chk("run off", 32'h0, {31'h0, run});
    for (int i = 1; i < 5; i++) begin
      rm.send(8'(8'h11 * i));
    end
    @(posedge ref_clk_i);
    #1;
    chk("fifo full", 32'h0, {31'h0, br});
    chk("no mem in idle", 32'h3, qa.size());
    wr(`UTE_OFS_RX_DRAIN, 32'h1);
    repeat (8) @(posedge ref_clk_i);
    chk("drain all", 32'h7, qa.size());
    chk("drain last", 32'h44, {24'h0, qd[6]});
    chk("drain addr", 32'h3, {24'h0, qa[6]});
    chk("fifo free", 32'h1, {31'h0, br});
    $display("test stop and drain done");
  endtask

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  initial begin
    repeat (16) @(posedge ref_clk_i);
    rst_i <= 1'b0;
    t_reset_values();
    t_triggers();
    t_cts();
    t_receive();
    t_drain();
    t_stop();
    give_verdict();
  end
endmodule
